// ### inc/cjm_pkg.sv
/*
 * Constants, encodings and types for the call, jump and byte-move
 * decoder of an 8-bit core.
 * Assumes a 256-byte internal RAM holding the four register banks
 * at its bottom and a 64K program space.
 */
`default_nettype none

package cjm_pkg;

	// ****************************************************************
	// Widths and reset values
	// ****************************************************************
	localparam int          PC_W       = 16;
	localparam int          BYTE_W     = 8;
	localparam logic [7:0]  SP_RESET   = 8'h07;
	localparam logic [15:0] PC_RESET   = 16'h0000;
	localparam logic [15:0] RET_OFFSET = 16'h0003;
	localparam logic [7:0]  SP_STEP    = 8'h01;
	localparam logic [15:0] PC_STEP    = 16'h0001;
	// Direct address of the accumulator, arbitrary default
	localparam logic [7:0]  ACC_DIRECT = 8'he0;

	// ****************************************************************
	// Opcodes, full bytes
	// ****************************************************************
	localparam logic [7:0] OPC_CALL     = 8'h12;
	localparam logic [7:0] OPC_JUMP     = 8'h02;
	localparam logic [7:0] OPC_A_DIR    = 8'he5;
	localparam logic [7:0] OPC_A_IMM    = 8'h74;
	localparam logic [7:0] OPC_DIR_A    = 8'hf5;
	localparam logic [7:0] OPC_DIR_DIR  = 8'h85;
	localparam logic [7:0] OPC_DIR_IMM  = 8'h75;

	// Opcode bits 7..3, low bits select a bank register
	localparam logic [4:0] OPC5_A_REG   = 5'h1d;
	localparam logic [4:0] OPC5_REG_A   = 5'h1f;
	localparam logic [4:0] OPC5_REG_DIR = 5'h15;
	localparam logic [4:0] OPC5_REG_IMM = 5'h0f;
	localparam logic [4:0] OPC5_DIR_REG = 5'h11;

	// Opcode bits 7..1, bit 0 selects a pointer register
	localparam logic [6:0] OPC7_A_IND   = 7'h73;
	localparam logic [6:0] OPC7_DIR_IND = 7'h43;
	localparam logic [6:0] OPC7_IND_A   = 7'h7b;
	localparam logic [6:0] OPC7_IND_DIR = 7'h53;
	localparam logic [6:0] OPC7_IND_IMM = 7'h3b;

	// ****************************************************************
	// Lengths and cycle counts
	// ****************************************************************
	localparam logic [1:0] LEN_1 = 2'h1;
	localparam logic [1:0] LEN_2 = 2'h2;
	localparam logic [1:0] LEN_3 = 2'h3;
	localparam logic [1:0] CYC_1 = 2'h1;
	localparam logic [1:0] CYC_2 = 2'h2;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {OP_MOVE, OP_CALL, OP_JUMP, OP_BAD} cjm_op_e;
	typedef enum logic [2:0] {
		SRC_ACC, SRC_REG, SRC_DIR, SRC_IND, SRC_IMM, SRC_IMM3
	} cjm_src_e;
	typedef enum logic [2:0] {
		DST_ACC, DST_REG, DST_DIR, DST_DIR3, DST_IND
	} cjm_dst_e;
	typedef enum logic [2:0] {
		ST_FETCH, ST_BYTE2, ST_BYTE3, ST_PTR_RD, ST_PTR_GET,
		ST_SRC_RD, ST_EXEC, ST_PUSH_HI
	} cjm_state_e;

endpackage : cjm_pkg

`default_nettype wire

// ### inc/cjm_if.sv
/*
 * Carriers between the decoder core, its opcode decoder and its RAM.
 * Assumes all parties run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface cjm_dec_if;
	cjm_pkg::cjm_op_e  op;
	cjm_pkg::cjm_src_e src;
	cjm_pkg::cjm_dst_e dst;
	logic [1:0]        len;
	logic [1:0]        cyc;
	modport dec  (output op, src, dst, len, cyc);
	modport core (input op, src, dst, len, cyc);
endinterface : cjm_dec_if

interface cjm_ram_if;
	logic       we;
	logic [7:0] waddr;
	logic [7:0] wdata;
	logic [7:0] raddr;
	logic [7:0] rdata;
	modport mem  (input we, waddr, wdata, raddr, output rdata);
	modport core (output we, waddr, wdata, raddr, input rdata);
endinterface : cjm_ram_if

`default_nettype wire

// ### rtl/cjm_ram.sv
/*
 * Internal data RAM, one write and one registered read port.
 * Assumes the core never relies on read-during-write ordering.
 */
`timescale 1ns/1ps
`default_nettype none

module cjm_ram #(
	parameter int DEPTH = 256
) (
	input  wire logic mclk,
	cjm_ram_if.mem    ram
);

	// ****************************************************************
	// Storage
	// ****************************************************************
	// Left without reset so it maps onto a RAM macro
	logic [7:0] mem [DEPTH];
	logic [7:0] rdata_ff;

	always_ff @(posedge mclk) begin
		if (ram.we) begin
			mem[ram.waddr] <= ram.wdata;
		end
		rdata_ff <= mem[ram.raddr];
	end

	assign ram.rdata = rdata_ff;

endmodule : cjm_ram

`default_nettype wire

// ### rtl/cjm_opdecode.sv
/*
 * Opcode classifier: operation, addressing of source and
 * destination, length in bytes and cycle count.
 * Assumes the opcode byte is stable for the whole cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module cjm_opdecode (
	input  wire logic [7:0] opcode,
	cjm_dec_if.dec          dec
);

	// ****************************************************************
	// Classification
	// ****************************************************************
	always_comb begin
		dec.op  = cjm_pkg::OP_MOVE;
		dec.src = cjm_pkg::SRC_ACC;
		dec.dst = cjm_pkg::DST_ACC;
		dec.len = cjm_pkg::LEN_1;
		dec.cyc = cjm_pkg::CYC_1;
		if (opcode == cjm_pkg::OPC_CALL) begin // RL1
			dec.op  = cjm_pkg::OP_CALL;
			dec.len = cjm_pkg::LEN_3;
			dec.cyc = cjm_pkg::CYC_2;
		end else if (opcode == cjm_pkg::OPC_JUMP) begin // RL4
			dec.op  = cjm_pkg::OP_JUMP;
			dec.len = cjm_pkg::LEN_3;
			dec.cyc = cjm_pkg::CYC_2;
		end else if (opcode[7:3] == cjm_pkg::OPC5_A_REG) begin // RL15
			dec.src = cjm_pkg::SRC_REG;
		end else if (opcode == cjm_pkg::OPC_A_DIR) begin // RL7
			dec.src = cjm_pkg::SRC_DIR;
			dec.len = cjm_pkg::LEN_2;
		end else if (opcode[7:1] == cjm_pkg::OPC7_A_IND) begin // RL8
			dec.src = cjm_pkg::SRC_IND;
		end else if (opcode == cjm_pkg::OPC_A_IMM) begin // RL9
			dec.src = cjm_pkg::SRC_IMM;
			dec.len = cjm_pkg::LEN_2;
		end else if (opcode[7:3] == cjm_pkg::OPC5_REG_A) begin // RL12
			dec.dst = cjm_pkg::DST_REG;
		end else if (opcode[7:3] == cjm_pkg::OPC5_REG_DIR) begin // RL11
			dec.src = cjm_pkg::SRC_DIR;
			dec.dst = cjm_pkg::DST_REG;
			dec.len = cjm_pkg::LEN_2;
			dec.cyc = cjm_pkg::CYC_2;
		end else if (opcode[7:3] == cjm_pkg::OPC5_REG_IMM) begin // RL10
			dec.src = cjm_pkg::SRC_IMM;
			dec.dst = cjm_pkg::DST_REG;
			dec.len = cjm_pkg::LEN_2;
		end else if (opcode == cjm_pkg::OPC_DIR_A) begin // RL16
			dec.dst = cjm_pkg::DST_DIR;
			dec.len = cjm_pkg::LEN_2;
		end else if (opcode[7:3] == cjm_pkg::OPC5_DIR_REG) begin // RL6
			dec.src = cjm_pkg::SRC_REG;
			dec.dst = cjm_pkg::DST_DIR;
			dec.len = cjm_pkg::LEN_2;
			dec.cyc = cjm_pkg::CYC_2;
		end else if (opcode == cjm_pkg::OPC_DIR_DIR) begin // RL13
			dec.src = cjm_pkg::SRC_DIR;
			dec.dst = cjm_pkg::DST_DIR3;
			dec.len = cjm_pkg::LEN_3;
			dec.cyc = cjm_pkg::CYC_2;
		end else if (opcode[7:1] == cjm_pkg::OPC7_DIR_IND) begin // RL14
			dec.src = cjm_pkg::SRC_IND;
			dec.dst = cjm_pkg::DST_DIR;
			dec.len = cjm_pkg::LEN_2;
			dec.cyc = cjm_pkg::CYC_2;
		end else if (opcode == cjm_pkg::OPC_DIR_IMM) begin // RL6
			dec.src = cjm_pkg::SRC_IMM3;
			dec.dst = cjm_pkg::DST_DIR;
			dec.len = cjm_pkg::LEN_3;
			dec.cyc = cjm_pkg::CYC_2;
		end else if (opcode[7:1] == cjm_pkg::OPC7_IND_A) begin // RL6
			dec.dst = cjm_pkg::DST_IND;
		end else if (opcode[7:1] == cjm_pkg::OPC7_IND_DIR) begin // RL6
			dec.src = cjm_pkg::SRC_DIR;
			dec.dst = cjm_pkg::DST_IND;
			dec.len = cjm_pkg::LEN_2;
			dec.cyc = cjm_pkg::CYC_2;
		end else if (opcode[7:1] == cjm_pkg::OPC7_IND_IMM) begin // RL6
			dec.src = cjm_pkg::SRC_IMM;
			dec.dst = cjm_pkg::DST_IND;
			dec.len = cjm_pkg::LEN_2;
		end else begin
			dec.op = cjm_pkg::OP_BAD;
		end
	end

endmodule : cjm_opdecode

`default_nettype wire

// ### rtl/cjm_core.sv
/*
 * Execution core for long call, long jump and the byte-move family.
 * Assumes code memory answers codeAddr combinationally in the same
 * cycle, and that direct addresses all map onto internal RAM.
 */
// Summary of operation
// RL1: Call opcode, three bytes, two cycles.
// RL2: Push PC plus three, low first.
// RL3: Call loads PC from bytes two, three.
// RL4: Jump loads PC, stack and flags untouched.
// RL5: Moves copy source only, nothing else.
// RL6: Fifteen move pairings, each own opcode.
// RL7: Accumulator from direct, accumulator address illegal.
// RL8: Accumulator from RAM via pointer register.
// RL9: Immediate byte into accumulator.
// RL10: Immediate byte into bank register.
// RL11: Direct location into bank register.
// RL12: Accumulator into bank register.
// RL13: Direct to direct, source first.
// RL14: Pointer-addressed RAM into direct location.
// RL15: Bank register into accumulator.
// RL16: Accumulator into direct location.
`timescale 1ns/1ps
`default_nettype none

module cjm_core #(
	parameter int RAM_DEPTH = 256
) (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  codeData,
	input  wire logic [1:0]  bankSel,
	output logic      [15:0] codeAddr,
	output logic      [7:0]  accOut,
	output logic      [7:0]  spOut,
	output logic             retire,
	output logic             illegal,
	output logic      [1:0]  instrLen,
	output logic      [1:0]  instrCycles
);

	// ****************************************************************
	// State
	// ****************************************************************
	cjm_pkg::cjm_state_e state_ff, nxt_state;
	cjm_pkg::cjm_state_e afterBytes;
	logic [15:0] pc_ff, nxt_pc, startPc_ff, nxt_startPc, retAddr;
	logic [7:0]  opcode_ff, nxt_opcode, byte2_ff, nxt_byte2;
	logic [7:0]  byte3_ff, nxt_byte3, ptr_ff, nxt_ptr;
	logic [7:0]  sp_ff, nxt_sp, acc_ff, nxt_acc;
	logic        retire_ff, nxt_retire, illegal_ff, nxt_illegal;
	logic [1:0]  len_ff, nxt_len, cyc_ff, nxt_cyc;
	logic [7:0]  opSel, moveData, srcAddr, dstAddr, regAddr, ptrAddr;
	logic        srcInRam, needPtr, badDirect;

	cjm_dec_if dec ();
	cjm_ram_if ram ();

	cjm_opdecode u_dec (
		.opcode (opSel),
		.dec    (dec)
	);

	cjm_ram #(.DEPTH(RAM_DEPTH)) u_ram (
		.mclk (mclk),
		.ram  (ram)
	);

	// ****************************************************************
	// Operand addressing
	// ****************************************************************
	// Decode the byte on the bus while fetching, then the latched one
	assign opSel     = (state_ff == cjm_pkg::ST_FETCH) ? codeData : opcode_ff;
	assign regAddr   = {3'h0, bankSel, opcode_ff[2:0]};
	assign ptrAddr   = {3'h0, bankSel, 2'h0, opcode_ff[0]};
	assign retAddr   = startPc_ff + cjm_pkg::RET_OFFSET; // RL2
	assign badDirect = (opcode_ff == cjm_pkg::OPC_A_DIR) &&
		(byte2_ff == cjm_pkg::ACC_DIRECT); // RL7
	assign srcInRam  = (dec.src == cjm_pkg::SRC_REG) ||
		(dec.src == cjm_pkg::SRC_DIR) || (dec.src == cjm_pkg::SRC_IND);
	assign needPtr   = (dec.src == cjm_pkg::SRC_IND) ||
		(dec.dst == cjm_pkg::DST_IND); // RL8

	always_comb begin
		srcAddr = byte2_ff;
		dstAddr = byte2_ff;
		if (dec.src == cjm_pkg::SRC_REG) begin
			srcAddr = regAddr;
		end else if (dec.src == cjm_pkg::SRC_IND) begin
			srcAddr = ptr_ff; // RL14
		end
		if (dec.dst == cjm_pkg::DST_REG) begin
			dstAddr = regAddr;
		end else if (dec.dst == cjm_pkg::DST_DIR3) begin
			dstAddr = byte3_ff; // RL13
		end else if (dec.dst == cjm_pkg::DST_IND) begin
			dstAddr = ptr_ff;
		end
		case (dec.src)
			cjm_pkg::SRC_ACC:  moveData = acc_ff;
			cjm_pkg::SRC_IMM:  moveData = byte2_ff; // RL9
			cjm_pkg::SRC_IMM3: moveData = byte3_ff;
			default:           moveData = ram.rdata;
		endcase
	end

	always_comb begin
		if (dec.op != cjm_pkg::OP_MOVE) begin
			afterBytes = cjm_pkg::ST_EXEC;
		end else if (needPtr) begin
			afterBytes = cjm_pkg::ST_PTR_RD;
		end else if (srcInRam) begin
			afterBytes = cjm_pkg::ST_SRC_RD;
		end else begin
			afterBytes = cjm_pkg::ST_EXEC;
		end
	end

	// ****************************************************************
	// Sequencer, next values
	// ****************************************************************
	always_comb begin
		nxt_state   = state_ff;
		nxt_pc      = pc_ff;
		nxt_startPc = startPc_ff;
		nxt_opcode  = opcode_ff;
		nxt_byte2   = byte2_ff;
		nxt_byte3   = byte3_ff;
		nxt_ptr     = ptr_ff;
		nxt_sp      = sp_ff;
		nxt_acc     = acc_ff;
		nxt_retire  = 1'b0;
		nxt_illegal = 1'b0;
		nxt_len     = len_ff;
		nxt_cyc     = cyc_ff;
		ram.we      = 1'b0;
		ram.waddr   = dstAddr;
		ram.wdata   = moveData;
		ram.raddr   = srcAddr;
		case (state_ff)
			cjm_pkg::ST_FETCH: begin
				nxt_opcode  = codeData;
				nxt_startPc = pc_ff;
				nxt_pc      = pc_ff + cjm_pkg::PC_STEP;
				nxt_state   = (dec.len == cjm_pkg::LEN_1) ?
					afterBytes : cjm_pkg::ST_BYTE2; // RL1
			end
			cjm_pkg::ST_BYTE2: begin
				nxt_byte2 = codeData;
				nxt_pc    = pc_ff + cjm_pkg::PC_STEP;
				nxt_state = (dec.len == cjm_pkg::LEN_3) ?
					cjm_pkg::ST_BYTE3 : afterBytes;
			end
			cjm_pkg::ST_BYTE3: begin
				nxt_byte3 = codeData;
				nxt_pc    = pc_ff + cjm_pkg::PC_STEP;
				nxt_state = afterBytes;
			end
			cjm_pkg::ST_PTR_RD: begin
				ram.raddr = ptrAddr; // RL8
				nxt_state = cjm_pkg::ST_PTR_GET;
			end
			cjm_pkg::ST_PTR_GET: begin
				nxt_ptr   = ram.rdata;
				nxt_state = srcInRam ? cjm_pkg::ST_SRC_RD : cjm_pkg::ST_EXEC;
			end
			cjm_pkg::ST_SRC_RD: begin
				nxt_state = cjm_pkg::ST_EXEC;
			end
			cjm_pkg::ST_EXEC: begin
				nxt_state = cjm_pkg::ST_FETCH;
				nxt_len   = dec.len;
				nxt_cyc   = dec.cyc;
				if (dec.op == cjm_pkg::OP_CALL) begin
					nxt_sp    = sp_ff + cjm_pkg::SP_STEP; // RL2
					ram.we    = 1'b1;
					ram.waddr = nxt_sp;
					ram.wdata = retAddr[7:0];
					nxt_state = cjm_pkg::ST_PUSH_HI;
				end else if (dec.op == cjm_pkg::OP_JUMP) begin
					nxt_pc     = {byte2_ff, byte3_ff}; // RL4
					nxt_retire = 1'b1;
				end else if (dec.op == cjm_pkg::OP_BAD || badDirect) begin
					// No write at all, so a bad opcode cannot corrupt state
					nxt_illegal = 1'b1; // RL7
					nxt_retire  = 1'b1;
				end else begin
					nxt_retire = 1'b1;
					if (dec.dst == cjm_pkg::DST_ACC) begin
						nxt_acc = moveData; // RL5
					end else begin
						ram.we = 1'b1; // RL5
					end
				end
			end
			cjm_pkg::ST_PUSH_HI: begin
				nxt_sp     = sp_ff + cjm_pkg::SP_STEP; // RL2
				ram.we     = 1'b1;
				ram.waddr  = nxt_sp;
				ram.wdata  = retAddr[15:8];
				nxt_pc     = {byte2_ff, byte3_ff}; // RL3
				nxt_retire = 1'b1;
				nxt_state  = cjm_pkg::ST_FETCH;
			end
			default: begin
				nxt_state = cjm_pkg::ST_FETCH;
			end
		endcase
	end

	// ****************************************************************
	// Sequencer, registers
	// ****************************************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff   <= cjm_pkg::ST_FETCH;
			pc_ff      <= cjm_pkg::PC_RESET;
			startPc_ff <= cjm_pkg::PC_RESET;
			opcode_ff  <= 8'h00;
			byte2_ff   <= 8'h00;
			byte3_ff   <= 8'h00;
			ptr_ff     <= 8'h00;
			sp_ff      <= cjm_pkg::SP_RESET;
			acc_ff     <= 8'h00;
			retire_ff  <= 1'b0;
			illegal_ff <= 1'b0;
			len_ff     <= 2'h0;
			cyc_ff     <= 2'h0;
		end else begin
			state_ff   <= nxt_state;
			pc_ff      <= nxt_pc;
			startPc_ff <= nxt_startPc;
			opcode_ff  <= nxt_opcode;
			byte2_ff   <= nxt_byte2;
			byte3_ff   <= nxt_byte3;
			ptr_ff     <= nxt_ptr;
			sp_ff      <= nxt_sp;
			acc_ff     <= nxt_acc;
			retire_ff  <= nxt_retire;
			illegal_ff <= nxt_illegal;
			len_ff     <= nxt_len;
			cyc_ff     <= nxt_cyc;
		end
	end

	assign codeAddr    = pc_ff;
	assign accOut      = acc_ff;
	assign spOut       = sp_ff;
	assign retire      = retire_ff;
	assign illegal     = illegal_ff;
	assign instrLen    = len_ff;
	assign instrCycles = cyc_ff;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	logic execCall, execJump, execMove;
	assign execCall = (state_ff == cjm_pkg::ST_EXEC) &&
		(dec.op == cjm_pkg::OP_CALL);
	assign execJump = (state_ff == cjm_pkg::ST_EXEC) &&
		(dec.op == cjm_pkg::OP_JUMP);
	assign execMove = (state_ff == cjm_pkg::ST_EXEC) &&
		(dec.op == cjm_pkg::OP_MOVE) && !badDirect;

	call_shape_a: assert property (execCall |=> ##1 retire_ff && // RL1
		len_ff == cjm_pkg::LEN_3 && cyc_ff == cjm_pkg::CYC_2)
		else $error("call retired with wrong length or cycles");
	call_push_a: assert property (execCall |-> ram.we && // RL2
		ram.waddr == sp_ff + cjm_pkg::SP_STEP &&
		ram.wdata == retAddr[7:0] ##1 ram.we &&
		ram.wdata == $past(retAddr[15:8]))
		else $error("return address pushed in wrong order");
	call_sp_a: assert property (execCall |=> ##1 // RL2
		sp_ff == $past(sp_ff, 2) + 8'h02)
		else $error("stack pointer not advanced by two");
	call_target_a: assert property (execCall |=> ##1 // RL3
		pc_ff == {byte2_ff, byte3_ff})
		else $error("call target not loaded");
	jump_target_a: assert property (execJump |=> // RL4
		pc_ff == $past({byte2_ff, byte3_ff}) && $stable(sp_ff) &&
		!$past(ram.we))
		else $error("jump target wrong or stack touched");
	move_acc_a: assert property (execMove && // RL5
		dec.dst == cjm_pkg::DST_ACC |=> acc_ff == $past(moveData) &&
		$stable(sp_ff) && !$past(ram.we))
		else $error("accumulator move wrong");
	move_ram_a: assert property (execMove && // RL5
		dec.dst != cjm_pkg::DST_ACC |=> $stable(acc_ff) &&
		$past(ram.we) && $past(ram.waddr) ==
		$past((opcode_ff == cjm_pkg::OPC_DIR_DIR) ? byte3_ff :
		(dec.dst == cjm_pkg::DST_REG) ? {3'h0, bankSel, opcode_ff[2:0]} :
		(dec.dst == cjm_pkg::DST_IND) ? ptr_ff : byte2_ff))
		else $error("RAM move wrong");
	bad_direct_a: assert property ((state_ff == cjm_pkg::ST_EXEC) && // RL7
		badDirect |-> !ram.we ##1 illegal_ff && $stable(acc_ff))
		else $error("illegal direct operand not refused");
	ptr_read_a: assert property (state_ff == cjm_pkg::ST_PTR_RD |-> // RL8
		ram.raddr == {3'h0, bankSel, 2'h0, opcode_ff[0]} ##1
		state_ff == cjm_pkg::ST_PTR_GET)
		else $error("pointer register read at wrong address");

	call_seen_c:  cover property (execCall ##2 retire_ff);
	jump_seen_c:  cover property (execJump ##1 retire_ff);
	ind_move_c:   cover property (state_ff == cjm_pkg::ST_PTR_GET ##2
		execMove);
	illegal_c:    cover property (illegal_ff);

endmodule : cjm_core

`default_nettype wire

// ### test/testbench.sv
/*
 * Self-checking bench for the call, jump and byte-move core.
 * Assumes cjm_core with its RAM inside; the bench plays code memory.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;

	// ****************************************************************
	// Clock, reset and code memory
	// ****************************************************************
	logic        mclk;
	logic        rst_n;
	logic [7:0]  codeData;
	logic [1:0]  bankSel;
	logic [15:0] codeAddr;
	logic [7:0]  accOut;
	logic [7:0]  spOut;
	logic        retire;
	logic        illegal;
	logic [1:0]  instrLen;
	logic [1:0]  instrCycles;
	logic [7:0]  rom [0:65535];
	logic [15:0] expPc;
	int          err_total;
	int          checks;

	initial mclk = 1'b0;
	always #20 mclk = ~mclk;

	// Code memory answers in the same cycle, as the core expects
	assign codeData = rom[codeAddr];

	cjm_core uut (
		.mclk        (mclk),
		.rst_n       (rst_n),
		.codeData    (codeData),
		.bankSel     (bankSel),
		.codeAddr    (codeAddr),
		.accOut      (accOut),
		.spOut       (spOut),
		.retire      (retire),
		.illegal     (illegal),
		.instrLen    (instrLen),
		.instrCycles (instrCycles)
	);

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic chk(input string nm, input logic [15:0] ex,
			input logic [15:0] got);
		checks++;
		if (got !== ex) begin
			$display("mismatch %s expected %h seen %h", nm, ex, got);
			err_total++;
		end
	endtask : chk

	// Places one instruction at the expected PC and waits for retire
	task automatic run(input logic [7:0] b0, input logic [7:0] b1,
			input logic [7:0] b2, input logic [1:0] len,
			input logic [1:0] cyc, input logic ill,
			input logic [15:0] nxt);
		int n;
		rom[expPc] = b0;
		rom[expPc + 16'h0001] = b1;
		rom[expPc + 16'h0002] = b2;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (retire !== 1'b1 && n < 12);
		chk("retire", 16'h0001, {15'h0000, retire});
		chk("illegal", {15'h0000, ill}, {15'h0000, illegal});
		if (!ill) begin
			chk("instrLen", {14'h0000, len}, {14'h0000, instrLen});
			chk("instrCycles", {14'h0000, cyc}, {14'h0000, instrCycles});
		end
		chk("codeAddr", nxt, codeAddr);
		expPc = nxt;
	endtask : run

	task automatic mv(input logic [7:0] b0, input logic [7:0] b1,
			input logic [7:0] b2, input logic [1:0] len,
			input logic [1:0] cyc);
		run(b0, b1, b2, len, cyc, 1'b0, expPc + {14'h0000, len});
	endtask : mv

	task automatic acc(input logic [7:0] ex);
		chk("accOut", {8'h00, ex}, {8'h00, accOut});
	endtask : acc

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset;
		chk("codeAddr", 16'h0000, codeAddr);
		chk("spOut", 16'h0007, {8'h00, spOut});
		acc(8'h00);
		chk("retire", 16'h0000, {15'h0000, retire});
		$display("test reset done");
	endtask : t_reset

	task automatic t_regs;
		for (int r = 0; r < 8; r++) begin
			mv(8'(8'h78 + r), 8'(8'h10 + r), 8'h00, 2'h2, 2'h1);
		end
		for (int r = 0; r < 8; r++) begin
			mv(8'(8'he8 + r), 8'h00, 8'h00, 2'h1, 2'h1);
			acc(8'(8'h10 + r));
		end
		mv(8'h74, 8'h5a, 8'h00, 2'h2, 2'h1);
		acc(8'h5a);
		mv(8'hff, 8'h00, 8'h00, 2'h1, 2'h1);
		mv(8'h74, 8'h00, 8'h00, 2'h2, 2'h1);
		mv(8'hef, 8'h00, 8'h00, 2'h1, 2'h1);
		acc(8'h5a);
		bankSel = 2'h1;
		mv(8'h7b, 8'h99, 8'h00, 2'h2, 2'h1);
		bankSel = 2'h0;
		mv(8'heb, 8'h00, 8'h00, 2'h1, 2'h1);
		acc(8'h13);
		mv(8'he5, 8'h0b, 8'h00, 2'h2, 2'h1);
		acc(8'h99);
		chk("spOut", 16'h0007, {8'h00, spOut});
		$display("test regs done");
	endtask : t_regs

	task automatic t_direct;
		mv(8'h74, 8'h3c, 8'h00, 2'h2, 2'h1);
		mv(8'hf5, 8'h30, 8'h00, 2'h2, 2'h1);
		mv(8'h74, 8'h00, 8'h00, 2'h2, 2'h1);
		mv(8'he5, 8'h30, 8'h00, 2'h2, 2'h1);
		acc(8'h3c);
		mv(8'haa, 8'h30, 8'h00, 2'h2, 2'h2);
		mv(8'hea, 8'h00, 8'h00, 2'h1, 2'h1);
		acc(8'h3c);
		mv(8'h75, 8'h40, 8'h11, 2'h3, 2'h2);
		mv(8'h85, 8'h30, 8'h40, 2'h3, 2'h2);
		mv(8'he5, 8'h40, 8'h00, 2'h2, 2'h1);
		acc(8'h3c);
		mv(8'he5, 8'h30, 8'h00, 2'h2, 2'h1);
		acc(8'h3c);
		mv(8'h74, 8'h21, 8'h00, 2'h2, 2'h1);
		mv(8'h8a, 8'h50, 8'h00, 2'h2, 2'h2);
		mv(8'he5, 8'h50, 8'h00, 2'h2, 2'h1);
		acc(8'h3c);
		// Accumulator must survive both refused forms
		run(8'he5, 8'he0, 8'h00, 2'h2, 2'h1, 1'b1, expPc + 16'h0002);
		acc(8'h3c);
		run(8'ha5, 8'h00, 8'h00, 2'h1, 2'h1, 1'b1, expPc + 16'h0001);
		acc(8'h3c);
		$display("test direct done");
	endtask : t_direct

	task automatic t_indirect;
		mv(8'h78, 8'h30, 8'h00, 2'h2, 2'h1);
		mv(8'h79, 8'h60, 8'h00, 2'h2, 2'h1);
		mv(8'he6, 8'h00, 8'h00, 2'h1, 2'h1);
		acc(8'h3c);
		mv(8'h86, 8'h70, 8'h00, 2'h2, 2'h2);
		mv(8'h74, 8'h77, 8'h00, 2'h2, 2'h1);
		mv(8'hf7, 8'h00, 8'h00, 2'h1, 2'h1);
		mv(8'he5, 8'h70, 8'h00, 2'h2, 2'h1);
		acc(8'h3c);
		mv(8'ha6, 8'h60, 8'h00, 2'h2, 2'h2);
		mv(8'he6, 8'h00, 8'h00, 2'h1, 2'h1);
		acc(8'h77);
		mv(8'h77, 8'he4, 8'h00, 2'h2, 2'h1);
		mv(8'he7, 8'h00, 8'h00, 2'h1, 2'h1);
		acc(8'he4);
		$display("test indirect done");
	endtask : t_indirect

	task automatic t_jump;
		// Stack bytes preset so a push of zero is visible
		mv(8'h75, 8'h08, 8'hee, 2'h3, 2'h2);
		mv(8'h75, 8'h09, 8'hee, 2'h3, 2'h2);
		run(8'h02, 8'h12, 8'h34, 2'h3, 2'h2, 1'b0, 16'h1234);
		chk("spOut", 16'h0007, {8'h00, spOut});
		acc(8'he4);
		// Top of program space, so the return address wraps
		run(8'h02, 8'hff, 8'hfd, 2'h3, 2'h2, 1'b0, 16'hfffd);
		$display("test jump done");
	endtask : t_jump

	task automatic t_call;
		run(8'h12, 8'h01, 8'h00, 2'h3, 2'h2, 1'b0, 16'h0100);
		chk("spOut", 16'h0009, {8'h00, spOut});
		mv(8'he5, 8'h08, 8'h00, 2'h2, 2'h1);
		acc(8'h00);
		mv(8'he5, 8'h09, 8'h00, 2'h2, 2'h1);
		acc(8'h00);
		run(8'h12, 8'hab, 8'hcd, 2'h3, 2'h2, 1'b0, 16'habcd);
		chk("spOut", 16'h000b, {8'h00, spOut});
		mv(8'he5, 8'h0a, 8'h00, 2'h2, 2'h1);
		acc(8'h07);
		mv(8'he5, 8'h0b, 8'h00, 2'h2, 2'h1);
		acc(8'h01);
		$display("test call done");
	endtask : t_call

	// ****************************************************************
	// Main sequence and watchdog
	// ****************************************************************
	initial begin
		rst_n = 1'b0;
		bankSel = 2'h0;
		expPc = 16'h0000;
		err_total = 0;
		checks = 0;
		repeat (10) @(negedge mclk);
		t_reset();
		rst_n = 1'b1;
		t_regs();
		t_direct();
		t_indirect();
		t_jump();
		t_call();
		end_sim();
	end

	// Whole run is well under a thousand cycles
	initial begin
		#(40 * 4000);
		err_total++;
		end_sim();
	end

endmodule : testbench

`default_nettype wire
